// ==== hdl/fbpt_pkg.sv ====
// constants for the flash block protect and timing controller
package fbpt_pkg;
    localparam int unsigned CLK_MHZ = 20;
    localparam int unsigned NUM_WORDS = 2048;
    localparam int unsigned WORD_AW = 11;
    localparam int unsigned BLOCK_WORDS = 256;
    localparam int unsigned BLOCK_SHIFT = 8;
    localparam int unsigned UNIT_SHIFT = 9;
    localparam int unsigned NUM_UNITS = 4;
    localparam int unsigned PROG_US = 20;
    localparam int unsigned ERASE_US = 40;
    localparam int unsigned COMMIT_US = 20;
    localparam logic [7:0] USEC_RESET = 8'h31;
    localparam logic [7:0] USEC_20MHZ = 8'(CLK_MHZ - 1);
    localparam logic [11:0] ADDR_TARGET = 12'h000;
    localparam logic [11:0] ADDR_WDATA = 12'h004;
    localparam logic [11:0] ADDR_CMD = 12'h008;
    localparam logic [11:0] ADDR_RAW = 12'h00C;
    localparam logic [11:0] ADDR_IMASK = 12'h010;
    localparam logic [11:0] ADDR_MISC = 12'h014;
    localparam logic [11:0] ADDR_USEC = 12'h140;
    localparam logic [11:0] ADDR_RDEN = 12'h200;
    localparam logic [11:0] ADDR_PGEN = 12'h400;
    localparam logic [11:0] ADDR_ARRAY = 12'h800;
    localparam logic [15:0] CMD_KEY = 16'hA442;
    localparam int unsigned CMD_WRITE_BIT = 0;
    localparam int unsigned CMD_ERASE_BIT = 1;
    localparam int unsigned CMD_COMMIT_BIT = 3;
    localparam logic [31:0] COMMIT_RDEN_ADDR = 32'h0000_0000;
    localparam logic [31:0] COMMIT_PGEN_ADDR = 32'h0000_0001;
    localparam logic [NUM_UNITS-1:0] POLICY_OPEN = 4'hF;
    typedef enum logic [1:0] {
        FBPT_IDLE = 2'b00,
        FBPT_BUSY = 2'b01,
        FBPT_DONE = 2'b11
    } fbpt_state_t;
endpackage

// ==== hdl/fbpt_us_timer.sv ====
// microsecond tick and operation duration counter
`timescale 1ns/10ps
module fbpt_us_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] reload,
    input wire logic start,
    input wire logic [7:0] dur_us,
    output logic done
);
    logic [7:0] cyc_q;
    logic [7:0] us_q;
    logic run_q;

    // one microsecond elapses every reload+1 cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= 8'h00;
            us_q <= 8'h00;
            run_q <= 1'b0;
        end else if (start) begin
            cyc_q <= reload;
            us_q <= dur_us;
            run_q <= 1'b1;
        end else if (run_q) begin
            if (cyc_q != 8'h00) begin
                cyc_q <= cyc_q - 8'h01;
            end else begin
                cyc_q <= reload;
                us_q <= us_q - 8'h01;
                if (us_q == 8'h01) begin
                    run_q <= 1'b0;
                end
            end
        end
    end

    assign done = run_q && (cyc_q == 8'h00) && (us_q == 8'h01);
endmodule

// ==== hdl/fbpt_ctrl.sv ====
// flash controller with block protection and microsecond timing
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
module fbpt_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fetch_req,
    input wire logic [10:0] fetch_word,
    output logic [31:0] fetch_data,
    input wire logic recover_req,
    output logic busy,
    output logic ctrl_irq
);
    logic [31:0] mem [fbpt_pkg::NUM_WORDS];
    logic [31:0] target_q;
    logic [31:0] wdata_q;
    logic [7:0] usec_q;
    logic [fbpt_pkg::NUM_UNITS-1:0] pgen_q;
    logic [fbpt_pkg::NUM_UNITS-1:0] rden_q;
    // stored copy has no reset: a power-on keeps what was committed
    logic [fbpt_pkg::NUM_UNITS-1:0] pgen_nv_q = fbpt_pkg::POLICY_OPEN;
    logic [fbpt_pkg::NUM_UNITS-1:0] rden_nv_q = fbpt_pkg::POLICY_OPEN;
    logic [fbpt_pkg::NUM_UNITS-1:0] pgen_eff;
    logic [fbpt_pkg::NUM_UNITS-1:0] rden_eff;
    logic [3:0] cmd_q;
    logic [3:0] cmd_d;
    logic pviol_q;
    logic rviol_q;
    logic pmask_q;
    logic rmask_q;
    fbpt_pkg::fbpt_state_t state_q;
    fbpt_pkg::fbpt_state_t state_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] fdata_q;

    // bus decode
    logic acc;
    logic wr;
    logic rd;
    logic [10:0] word_idx;
    logic [1:0] unit_idx;
    logic cmd_wr;
    logic key_ok;
    logic timer_start;
    logic timer_done;
    logic [7:0] dur_us;
    logic [1:0] arr_unit;
    logic arr_rd;
    logic rd_block;
    logic prog_ok;

    logic wr_target;
    logic wr_wdata;
    logic wr_usec;
    logic wr_imask;
    logic wr_misc;
    logic wr_pgen;
    logic wr_rden;
    logic setup_rd;

    logic op_end;
    logic prog_done;
    logic erase_done;
    logic commit_done;

    logic pviol_set;
    logic pviol_clr;
    logic rviol_set;
    logic rviol_clr;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign setup_rd = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign busy = (state_q != fbpt_pkg::FBPT_IDLE);

    // target holds a word index; a unit spans two erase blocks
    assign word_idx = target_q[10:0];
    assign unit_idx = target_q[10:9];
    assign arr_unit = paddr[10:9];
    assign arr_rd = rd && paddr[11];
    // policy in force: live bits limited by the stored copy
    assign pgen_eff = pgen_q & pgen_nv_q;
    assign rden_eff = rden_q & rden_nv_q;
    assign prog_ok = pgen_eff[unit_idx];
    assign rd_block = !rden_eff[arr_unit];

    // one-cycle write strobes, taken in the access phase
    assign wr_target = wr && (paddr == fbpt_pkg::ADDR_TARGET) && !busy;
    assign wr_wdata = wr && (paddr == fbpt_pkg::ADDR_WDATA) && !busy;
    assign wr_usec = wr && (paddr == fbpt_pkg::ADDR_USEC);
    assign wr_imask = wr && (paddr == fbpt_pkg::ADDR_IMASK);
    assign wr_misc = wr && (paddr == fbpt_pkg::ADDR_MISC);
    assign wr_pgen = wr && (paddr == fbpt_pkg::ADDR_PGEN);
    assign wr_rden = wr && (paddr == fbpt_pkg::ADDR_RDEN);
    assign key_ok = (pwdata[31:16] == fbpt_pkg::CMD_KEY);
    assign cmd_wr = wr && (paddr == fbpt_pkg::ADDR_CMD) && key_ok && !busy;
    assign timer_start = cmd_wr && (pwdata[3:0] != 4'h0) &&
        (pwdata[3] || prog_ok);
    assign dur_us = pwdata[fbpt_pkg::CMD_ERASE_BIT] ? 8'(fbpt_pkg::ERASE_US) :
        pwdata[fbpt_pkg::CMD_COMMIT_BIT] ? 8'(fbpt_pkg::COMMIT_US) :
        8'(fbpt_pkg::PROG_US);

    assign op_end = (state_q == fbpt_pkg::FBPT_DONE);
    assign prog_done = op_end && cmd_q[fbpt_pkg::CMD_WRITE_BIT];
    assign erase_done = op_end && !cmd_q[fbpt_pkg::CMD_WRITE_BIT] &&
        cmd_q[fbpt_pkg::CMD_ERASE_BIT];
    assign commit_done = op_end && cmd_q[fbpt_pkg::CMD_COMMIT_BIT];

    // a change aimed at a closed unit is flagged, and dropped unless the commit bit is also set
    assign pviol_set = cmd_wr && (pwdata[1:0] != 2'b00) && !prog_ok;
    assign pviol_clr = wr_misc && pwdata[0];
    assign rviol_set = arr_rd && rd_block;
    assign rviol_clr = wr_misc && pwdata[1];
    assign ctrl_irq = (pviol_q && pmask_q) || (rviol_q && rmask_q);

    // tick base follows the reload live, even mid-operation
    fbpt_us_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .reload(usec_q),
        .start(timer_start),
        .dur_us(dur_us),
        .done(timer_done)
    );

    // target and data hold still while an operation runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
        end else begin
            if (wr_target) begin
                target_q <= pwdata;
            end
            if (wr_wdata) begin
                wdata_q <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usec_q <= fbpt_pkg::USEC_RESET;
        end else if (wr_usec) begin
            usec_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pmask_q <= 1'b0;
            rmask_q <= 1'b0;
        end else if (wr_imask) begin
            pmask_q <= pwdata[0];
            rmask_q <= pwdata[1];
        end
    end

    // sequencer next state; the flag bits stay set until the operation ends
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        case (state_q)
            fbpt_pkg::FBPT_IDLE: begin
                if (timer_start) begin
                    cmd_d = pwdata[3:0];
                    state_d = fbpt_pkg::FBPT_BUSY;
                end
            end
            fbpt_pkg::FBPT_BUSY: begin
                if (timer_done) begin
                    state_d = fbpt_pkg::FBPT_DONE;
                end
            end
            fbpt_pkg::FBPT_DONE: begin
                cmd_d = 4'h0;
                state_d = fbpt_pkg::FBPT_IDLE;
            end
            default: begin
                cmd_d = 4'h0;
                state_d = fbpt_pkg::FBPT_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= fbpt_pkg::FBPT_IDLE;
            cmd_q <= 4'h0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
        end
    end

    // array has no reset: its contents are the flash cells
    always_ff @(posedge pclk) begin
        if (recover_req) begin
            for (int i = 0; i < fbpt_pkg::NUM_WORDS; i++) begin
                mem[i] <= 32'hFFFF_FFFF;
            end
        end else if (prog_done) begin
            mem[word_idx] <= mem[word_idx] & wdata_q;
        end else if (erase_done) begin
            for (int i = 0; i < fbpt_pkg::BLOCK_WORDS; i++) begin
                mem[{word_idx[10:8], 8'(i)}] <= 32'hFFFF_FFFF;
            end
        end
    end

    // stored copy: a commit only lowers it, recovery raises it
    always_ff @(posedge pclk) begin
        if (recover_req) begin
            pgen_nv_q <= fbpt_pkg::POLICY_OPEN;
            rden_nv_q <= fbpt_pkg::POLICY_OPEN;
        end else if (commit_done) begin
            if (target_q == fbpt_pkg::COMMIT_PGEN_ADDR) begin
                pgen_nv_q <= pgen_nv_q & pgen_q;
            end
            if (target_q == fbpt_pkg::COMMIT_RDEN_ADDR) begin
                rden_nv_q <= rden_nv_q & rden_q;
            end
        end
    end

    // live copy; reset reopens it so only committed clears survive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pgen_q <= fbpt_pkg::POLICY_OPEN;
        end else if (recover_req) begin
            pgen_q <= fbpt_pkg::POLICY_OPEN;
        end else if (wr_pgen) begin
            pgen_q <= pgen_q & pwdata[fbpt_pkg::NUM_UNITS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rden_q <= fbpt_pkg::POLICY_OPEN;
        end else if (recover_req) begin
            rden_q <= fbpt_pkg::POLICY_OPEN;
        end else if (wr_rden) begin
            rden_q <= rden_q & pwdata[fbpt_pkg::NUM_UNITS-1:0];
        end
    end

    // sticky violation flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pviol_q <= 1'b0;
        end else begin
            pviol_q <= (pviol_q && !pviol_clr) || pviol_set;
        end
    end

    // read violations come from data reads only, never from fetches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rviol_q <= 1'b0;
        end else begin
            rviol_q <= (rviol_q && !rviol_clr) || rviol_set;
        end
    end

    // read data chosen in the setup phase, so pready can stand high at once
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (paddr[11]) begin
            if (!rd_block) begin
                rdata_d = mem[paddr[10:0]];
            end
        end else begin
            case (paddr)
                fbpt_pkg::ADDR_TARGET: rdata_d = target_q;
                fbpt_pkg::ADDR_WDATA: rdata_d = wdata_q;
                fbpt_pkg::ADDR_CMD: rdata_d = {28'h0000000, cmd_q};
                fbpt_pkg::ADDR_RAW: rdata_d = {30'h00000000, rviol_q, pviol_q};
                fbpt_pkg::ADDR_IMASK: rdata_d = {30'h00000000, rmask_q, pmask_q};
                fbpt_pkg::ADDR_MISC: rdata_d = {30'h00000000, rviol_q && rmask_q,
                    pviol_q && pmask_q};
                fbpt_pkg::ADDR_USEC: rdata_d = {24'h000000, usec_q};
                fbpt_pkg::ADDR_PGEN: rdata_d = {28'h0000000, pgen_eff};
                fbpt_pkg::ADDR_RDEN: rdata_d = {28'h0000000, rden_eff};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // prdata stands from one setup phase until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // fetch ignores read enable: execution is always allowed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fdata_q <= 32'h0000_0000;
        end else if (fetch_req) begin
            fdata_q <= mem[fetch_word];
        end
    end

    assign prdata = rdata_q;
    assign fetch_data = fdata_q;
endmodule

// ==== verification/fbpt_core_model.sv ====
// core and debugger side: apb master and instruction fetch port
`timescale 1ns/10ps
module fbpt_core_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    output logic fetch_req,
    output logic [10:0] fetch_word,
    input wire logic [31:0] fetch_data
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fetch_req = 1'b0;
        fetch_word = 11'h000;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // stale data must not look valid after release
        pwdata <= ~d;
        @(posedge pclk);
    endtask
    task automatic fetch(input logic [10:0] w, output logic [31:0] q);
        fetch_req <= 1'b1;
        fetch_word <= w;
        repeat (3) @(posedge pclk);
        q = fetch_data;
        fetch_req <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// ==== verification/fbpt_ctrl_asserts.sv ====
// port checks for the flash protect and timing controller
`timescale 1ns/10ps
module fbpt_ctrl_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic recover_req,
    input wire logic busy,
    input wire logic ctrl_irq
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc, rd_usec, wr_cmd, clr;
    logic [1:0] mask_q;
    logic [3:0] pg_q, re_q;
    logic [10:0] tgt_q;
    logic [7:0] usec_q;
    logic usec_w_q;
    assign acc = psel && penable && pready;
    assign rd_usec = acc && !pwrite && paddr == fbpt_pkg::ADDR_USEC;
    assign wr_cmd = acc && pwrite && paddr == fbpt_pkg::ADDR_CMD;
    assign clr = recover_req || (acc && pwrite && paddr inside {12'h010, 12'h014});
    // only cleared bits are trusted, so commits never make this pessimistic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 2'h0;
            pg_q <= 4'hF;
            re_q <= 4'hF;
            tgt_q <= 11'h000;
            usec_q <= 8'h00;
            usec_w_q <= 1'b0;
        end else if (acc && pwrite) begin
            case (paddr)
                fbpt_pkg::ADDR_IMASK: mask_q <= pwdata[1:0];
                fbpt_pkg::ADDR_PGEN: pg_q <= pg_q & pwdata[3:0];
                fbpt_pkg::ADDR_RDEN: re_q <= re_q & pwdata[3:0];
                fbpt_pkg::ADDR_TARGET: tgt_q <= pwdata[10:0];
                fbpt_pkg::ADDR_USEC: begin
                    usec_q <= pwdata[7:0];
                    usec_w_q <= 1'b1;
                end
                default: ;
            endcase
        end
    end
    sequence s_prot_cmd;
        wr_cmd && pwdata[31:16] == fbpt_pkg::CMD_KEY && (|pwdata[1:0])
            && !pg_q[tgt_q[10:9]] && !busy;
    endsequence
    property p_pe_block;
        s_prot_cmd |=> !busy [*3];
    endproperty
    a_pe_block: assert property (p_pe_block)
        else $error("change of protected unit started");
    property p_pe_irq;
        s_prot_cmd and mask_q[0] |-> ##[1:4] ctrl_irq;
    endproperty
    a_pe_irq: assert property (p_pe_irq)
        else $error("no interrupt for blocked change");
    property p_irq_mask;
        (mask_q == 2'h0) [*2] |-> !ctrl_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt with all masks clear");
    property p_irq_sticky;
        ctrl_irq && !clr && !$past(clr) |=> ctrl_irq;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("interrupt dropped without clear");
    property p_reload_reset;
        rd_usec && !usec_w_q |-> prdata[7:0] == fbpt_pkg::USEC_RESET;
    endproperty
    a_reload_reset: assert property (p_reload_reset)
        else $error("reload reset value wrong");
    property p_reload_rb;
        rd_usec && usec_w_q |-> prdata[7:0] == usec_q;
    endproperty
    a_reload_rb: assert property (p_reload_rb)
        else $error("reload readback wrong");
    property p_read_block;
        acc && !pwrite && paddr[11] && !re_q[paddr[10:9]] |-> prdata == 32'h0;
    endproperty
    a_read_block: assert property (p_read_block)
        else $error("read of protected unit returned data");
    property p_busy_min;
        $rose(busy) |=> busy [*8];
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("operation shorter than timed minimum");
    property p_zero_wait;
        psel && penable |-> pready && !pslverr;
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("access not answered at once");
endmodule

// ==== verification/fbpt_ctrl_tb_top.sv ====
// testbench for the flash protect and timing controller
`timescale 1ns/10ps
module fbpt_ctrl_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic recover_req = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, fetch_req, busy, ctrl_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, fetch_data, q, f;
    logic [10:0] fetch_word;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    always #25 pclk = ~pclk;
    fbpt_core_model u_core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .fetch_req(fetch_req), .fetch_word(fetch_word), .fetch_data(fetch_data));
    fbpt_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_req(fetch_req), .fetch_word(fetch_word),
        .fetch_data(fetch_data), .recover_req(recover_req), .busy(busy), .ctrl_irq(ctrl_irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            fails++;
            finish_test();
        end
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_core.xfer(1'b1, a, d, q);
    endtask
    task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        u_core.xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    // busy cycles counted so the timed length can be judged
    task automatic run(input logic [10:0] t, input logic [31:0] cmd);
        wr(fbpt_pkg::ADDR_TARGET, {21'h0, t});
        if (cmd != 32'h0) wr(fbpt_pkg::ADDR_CMD, cmd);
        n = 0;
        repeat (2) @(posedge pclk);
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20000) fails++;
        if (cmd != 32'h0) rdm(fbpt_pkg::ADDR_CMD, 32'hF, 32'h0);
    endtask
    task automatic prog(input logic [10:0] w, input logic [31:0] d);
        wr(fbpt_pkg::ADDR_WDATA, d);
        run(w, 32'hA442_0001);
    endtask
    task automatic rst();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdm(fbpt_pkg::ADDR_USEC, 32'hFF, 32'h31);
        rdm(fbpt_pkg::ADDR_PGEN, 32'hF, 32'hF);
        rdm(fbpt_pkg::ADDR_RDEN, 32'hF, 32'hF);
        wr(fbpt_pkg::ADDR_USEC, 32'(fbpt_pkg::USEC_20MHZ));
        rdm(fbpt_pkg::ADDR_USEC, 32'hFF, 32'h13);
        for (int b = 0; b < 5; b++) run(11'(b * 256), 32'hA442_0002);
        prog(11'd255, 32'h0);
        prog(11'd256, 32'h0);
        run(11'd256, 32'hA442_0002);
        rdm(12'h8FF, '1, 32'h0);
        rdm(12'h900, '1, '1);
        prog(11'd5, 32'hF0F0_1234);
        chk(32'(n + 2 >= fbpt_pkg::PROG_US * 20), 32'h1);
        rdm(12'h805, '1, 32'hF0F0_1234);
        prog(11'd5, 32'h0FFF_FFFF);
        rdm(12'h805, '1, 32'h00F0_1234);
        wr(fbpt_pkg::ADDR_IMASK, 32'h3);
        wr(fbpt_pkg::ADDR_PGEN, 32'hFFFF_FFFA);
        wr(fbpt_pkg::ADDR_RDEN, 32'hFFFF_FFFC);
        prog(11'd5, 32'h0);
        run(11'd5, 32'hA442_0002);
        chk({31'h0, ctrl_irq}, 32'h1);
        u_core.fetch(11'd5, f);
        chk(f, 32'h00F0_1234);
        rdm(12'h805, '1, 32'h0);
        prog(11'd601, 32'h1234_5678);
        u_core.fetch(11'd601, f);
        chk(f, 32'h1234_5678);
        rdm(12'hA59, '1, 32'h0);
        prog(11'd1030, 32'h0);
        u_core.fetch(11'd1030, f);
        rdm(12'hC06, '1, f);
        chk(f, '1);
        wr(fbpt_pkg::ADDR_MISC, 32'h3);
        chk({31'h0, ctrl_irq}, 32'h0);
        rst();
        rdm(fbpt_pkg::ADDR_PGEN, 32'hF, 32'hF);
        rdm(fbpt_pkg::ADDR_RDEN, 32'hF, 32'hF);
        wr(fbpt_pkg::ADDR_PGEN, 32'hFFFF_FFFE);
        run(11'd1, 32'hA442_0008);
        rst();
        rdm(fbpt_pkg::ADDR_PGEN, 32'hF, 32'hE);
        wr(fbpt_pkg::ADDR_PGEN, '1);
        rdm(fbpt_pkg::ADDR_PGEN, 32'hF, 32'hE);
        recover_req <= 1'b1;
        @(posedge pclk);
        recover_req <= 1'b0;
        run(11'd0, 32'h0);
        rdm(fbpt_pkg::ADDR_PGEN, 32'hF, 32'hF);
        rdm(12'h805, '1, '1);
        finish_test();
    end
endmodule
bind fbpt_ctrl fbpt_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .recover_req(recover_req), .busy(busy),
    .ctrl_irq(ctrl_irq));
